// ===== periph_bridge_pkg.sv
// Shared constants and carrier types of the peripheral bridge register bank
package periph_bridge_pkg;

  // ----------------------------------------------------------------------
  // Widths and decode
  // ----------------------------------------------------------------------
  localparam int          REG_W            = 16;
  localparam int          ADDR_W           = 32;
  localparam int          DATA_W           = 32;
  localparam logic [31:0] PUBLIC_BASE_DEF  = 32'hFFFED300;
  localparam logic [31:0] PRIVATE_BASE_DEF = 32'hFFFECA00;
  localparam int          BASE_LSB         = 8;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_BRIDGE_CONTROL      = 8'h00;
  localparam logic [7:0] OFS_BUS_ALLOCATION      = 8'h04;
  localparam logic [7:0] OFS_CORE_BRIDGE_CONTROL = 8'h08;
  localparam logic [7:0] OFS_ENHANCED_CONTROL    = 8'h0C;
  localparam logic [7:0] OFS_ABORT_ADDRESS       = 8'h10;
  localparam logic [7:0] OFS_ABORT_DATA_LOW      = 8'h14;
  localparam logic [7:0] OFS_ABORT_DATA_HIGH     = 8'h18;
  localparam logic [7:0] OFS_ABORT_CONTROLS      = 8'h1C;
  localparam logic [7:0] OFS_PERMISSION_CONTROL  = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS          = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK            = 8'h28;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int STALL_LIMIT_LSB = 8;
  localparam int STALL_LIMIT_W   = 8;
  localparam int STROBE1_LSB     = 4;
  localparam int FACTOR_W        = 4;
  localparam int TIMEOUT_EN_BIT  = 0;
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  localparam int IRQ_W           = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_BRIDGE_CONTROL      = 16'hFF11;
  localparam logic [15:0] RST_BUS_ALLOCATION      = 16'h0000;
  localparam logic [15:0] RST_CORE_BRIDGE_CONTROL = 16'h0000;
  localparam logic [15:0] RST_ENHANCED_CONTROL    = 16'h0001;
  localparam logic [15:0] RST_PERMISSION_CONTROL  = 16'h0000;

  // ----------------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OWNER_CORE,
    OWNER_DMA,
    OWNER_SOCKET
  } owner_t;

  typedef struct packed {
    logic        start;
    owner_t      owner;
    logic        strobe1;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } access_req_t;

  typedef struct packed {
    logic       periph;
    logic [2:0] initiator;
  } abort_t;

  typedef struct packed {
    logic       busy;
    logic [7:0] count;
    owner_t     owner;
    abort_t     abort;
  } timer_state_t;

endpackage

// ===== access_timeout_counter.sv
// Access time-out counter that aborts stalled peripheral cycles
`timescale 1ns/1ps
module access_timeout_counter (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Access control
  input  wire logic                      start,
  input  wire periph_bridge_pkg::owner_t owner,
  input  wire logic                      done,
  input  wire logic [7:0]                stall_limit,
  input  wire logic                      enable,
  // Status
  output      logic                      busy,
  output      periph_bridge_pkg::abort_t abort
);

  periph_bridge_pkg::timer_state_t t;
  periph_bridge_pkg::timer_state_t next_t;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_t       = t;
    next_t.abort = '0;
    if (start) begin
      next_t.busy  = 1'b1;
      next_t.count = stall_limit;
      next_t.owner = owner;
    end else if (t.busy) begin
      if (done) begin
        next_t.busy = 1'b0;
      end else if (t.count == 8'h00) begin
        // Disabled: wait at zero so a late enable still fires
        if (enable) begin
          next_t.busy         = 1'b0;
          next_t.abort.periph = 1'b1;
          unique case (t.owner)
            periph_bridge_pkg::OWNER_CORE:
              next_t.abort.initiator = 3'h1;
            periph_bridge_pkg::OWNER_DMA:
              next_t.abort.initiator = 3'h2;
            default:
              next_t.abort.initiator = 3'h4;
          endcase
        end
      end else begin
        next_t.count = 8'(t.count - 8'h01);
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t <= '0;
    end else begin
      t <= next_t;
    end
  end

  assign busy  = t.busy;
  assign abort = t.abort;

endmodule

// ===== periph_bridge_regs_timeout.sv
// Register bank, strobe-1 stretcher and abort capture of the peripheral bridge
//
// Behaviour
// - Every configuration and debug register is sixteen bits wide; the IRQ status and mask registers here are two bits wide.
// - Writes take effect only in supervisor mode; user-mode writes are ignored.
// - Reads are allowed in both supervisor and user mode.
// - The same register set answers at the public and private bases.
// - Each access start loads the counter from control bits 15:8, reset 0xFF.
// - An access still open when the counter reaches zero is aborted.
// - The abort goes to the peripheral and to the owning initiator.
// - The stall limit holds values up to 255 only.
// - Control bits 7:4 hold the strobe-1 stretch factor, reset one.
// - Strobe period is 2n cycles; factor zero acts as factor one.
// - Strobe stays high n cycles, then low n cycles.
// - Time-out span is stall limit plus one clock periods.
// - An enable bit in the enhanced control register disables time-outs.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module periph_bridge_regs_timeout #(
  parameter logic [31:0] PUBLIC_BASE  = periph_bridge_pkg::PUBLIC_BASE_DEF,
  parameter logic [31:0] PRIVATE_BASE = periph_bridge_pkg::PRIVATE_BASE_DEF
) (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write address and data
  input  wire logic                         awvalid,
  output      logic                         awready,
  input  wire logic [31:0]                  awaddr,
  input  wire logic [2:0]                   awprot,
  input  wire logic                         wvalid,
  output      logic                         wready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  // AXI4-Lite write response
  output      logic                         bvalid,
  input  wire logic                         bready,
  output      logic [1:0]                   bresp,
  // AXI4-Lite read
  input  wire logic                         arvalid,
  output      logic                         arready,
  input  wire logic [31:0]                  araddr,
  input  wire logic [2:0]                   arprot,
  output      logic                         rvalid,
  input  wire logic                         rready,
  output      logic [31:0]                  rdata,
  output      logic [1:0]                   rresp,
  // Peripheral access from the arbitrated initiator
  input  wire periph_bridge_pkg::access_req_t access_req,
  input  wire logic                         periph_done,
  // Peripheral side
  output      logic                         strobe1_n,
  output      logic                         access_busy,
  // Aborts
  output      logic                         periph_abort,
  output      logic [2:0]                   initiator_abort,
  // Interrupt
  output      logic                         irq
);

  typedef struct packed {
    logic [15:0]        bridge_control;
    logic [15:0]        bus_allocation_control;
    logic [15:0]        core_bridge_control;
    logic [15:0]        enhanced_bridge_control;
    logic [15:0]        initiator_permission_control;
    logic [15:0]        abort_capture_address;
    logic [15:0]        abort_capture_data_low;
    logic [15:0]        abort_capture_data_high;
    logic [15:0]        abort_capture_controls;
    logic [1:0]         irq_status;
    logic [1:0]         irq_mask;
    logic               irq;
    logic               awready;
    logic               wready;
    logic               aw_held;
    logic               w_held;
    logic [31:0]        awaddr;
    logic               aw_priv;
    logic [15:0]        wdata;
    logic [1:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               active;
    logic               acc_strobe1;
    logic               acc_write;
    periph_bridge_pkg::owner_t acc_owner;
    logic [31:0]        acc_addr;
    logic [31:0]        acc_wdata;
    logic [3:0]         factor;
    logic [4:0]         phase;
    logic               strobe1_n;
  } main_state_t;

  main_state_t                 s;
  main_state_t                 next_s;
  logic                        start_ok;
  logic                        timer_busy;
  periph_bridge_pkg::abort_t   timer_abort;
  logic                        refused;
  logic [1:0]                  w1c;
  logic [1:0]                  events;
  logic [4:0]                  last_phase;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Both bases decode to one register set, so aliases are harmless
  function automatic logic mapped(input logic [31:0] a);
    logic base_ok;
    logic ofs_ok;
    base_ok = (a[31:periph_bridge_pkg::BASE_LSB] ==
               PUBLIC_BASE[31:periph_bridge_pkg::BASE_LSB]) ||
              (a[31:periph_bridge_pkg::BASE_LSB] ==
               PRIVATE_BASE[31:periph_bridge_pkg::BASE_LSB]);
    ofs_ok  = (a[1:0] == 2'h0) &&
              (a[7:0] <= periph_bridge_pkg::OFS_IRQ_MASK);
    return base_ok && ofs_ok;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] val,
                                        input logic [1:0]  be);
    logic [15:0] r;
    r       = old;
    if (be[0]) begin
      r[7:0] = val[7:0];
    end
    if (be[1]) begin
      r[15:8] = val[15:8];
    end
    return r;
  endfunction

  // A factor of zero stretches exactly like a factor of one
  function automatic logic [3:0] eff_factor(input logic [3:0] f);
    return (f == 4'h0) ? 4'h1 : f;
  endfunction

  // ----------------------------------------------------------------------
  // Time-out counter
  // ----------------------------------------------------------------------
  // On an abort the counter goes idle a cycle before the access does; wait for both
  assign start_ok = access_req.start && !s.active && !timer_busy;

  access_timeout_counter u_timeout (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .start       (start_ok),
    .owner       (access_req.owner),
    .done        (periph_done),
    .stall_limit (s.bridge_control[periph_bridge_pkg::STALL_LIMIT_LSB +:
                    periph_bridge_pkg::STALL_LIMIT_W]),
    .enable      (s.enhanced_bridge_control[
                    periph_bridge_pkg::TIMEOUT_EN_BIT]),
    .busy        (timer_busy),
    .abort       (timer_abort)
  );

  assign last_phase = 5'({eff_factor(s.factor), 1'b0} - 5'h01);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s  = s;
    refused = 1'b0;
    w1c     = '0;
    events  = '0;

    // Address and data are taken independently, in either order
    if (awvalid && s.awready) begin
      next_s.awready = 1'b0;
      next_s.aw_held = 1'b1;
      next_s.awaddr  = awaddr;
      next_s.aw_priv = awprot[0];
    end
    if (wvalid && s.wready) begin
      next_s.wready = 1'b0;
      next_s.w_held = 1'b1;
      next_s.wdata  = wdata[15:0];
      next_s.wstrb  = wstrb[1:0];
    end
    if (s.bvalid && bready) begin
      next_s.bvalid  = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end

    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = periph_bridge_pkg::RESP_OKAY;
      if (!mapped(s.awaddr)) begin
        next_s.bresp = periph_bridge_pkg::RESP_DECERR;
      end else if (!s.aw_priv) begin
        refused = 1'b1;
      end else begin
        case (s.awaddr[7:0])
          periph_bridge_pkg::OFS_BRIDGE_CONTROL:
            next_s.bridge_control = merge(s.bridge_control,
                                          s.wdata, s.wstrb);
          periph_bridge_pkg::OFS_BUS_ALLOCATION:
            next_s.bus_allocation_control =
              merge(s.bus_allocation_control, s.wdata, s.wstrb);
          periph_bridge_pkg::OFS_CORE_BRIDGE_CONTROL:
            next_s.core_bridge_control =
              merge(s.core_bridge_control, s.wdata, s.wstrb);
          periph_bridge_pkg::OFS_ENHANCED_CONTROL:
            next_s.enhanced_bridge_control =
              merge(s.enhanced_bridge_control, s.wdata, s.wstrb);
          periph_bridge_pkg::OFS_PERMISSION_CONTROL:
            next_s.initiator_permission_control =
              merge(s.initiator_permission_control, s.wdata, s.wstrb);
          periph_bridge_pkg::OFS_IRQ_STATUS:
            w1c = s.wstrb[0] ? s.wdata[1:0] : 2'h0;
          periph_bridge_pkg::OFS_IRQ_MASK:
            if (s.wstrb[0]) begin
              next_s.irq_mask = s.wdata[1:0];
            end
          default: ;
        endcase
      end
    end

    // Reads need no privilege
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = periph_bridge_pkg::RESP_OKAY;
      next_s.rdata   = 32'h00000000;
      if (!mapped(araddr)) begin
        next_s.rresp = periph_bridge_pkg::RESP_DECERR;
      end else begin
        case (araddr[7:0])
          periph_bridge_pkg::OFS_BRIDGE_CONTROL:
            next_s.rdata[15:0] = s.bridge_control;
          periph_bridge_pkg::OFS_BUS_ALLOCATION:
            next_s.rdata[15:0] = s.bus_allocation_control;
          periph_bridge_pkg::OFS_CORE_BRIDGE_CONTROL:
            next_s.rdata[15:0] = s.core_bridge_control;
          periph_bridge_pkg::OFS_ENHANCED_CONTROL:
            next_s.rdata[15:0] = s.enhanced_bridge_control;
          periph_bridge_pkg::OFS_ABORT_ADDRESS:
            next_s.rdata[15:0] = s.abort_capture_address;
          periph_bridge_pkg::OFS_ABORT_DATA_LOW:
            next_s.rdata[15:0] = s.abort_capture_data_low;
          periph_bridge_pkg::OFS_ABORT_DATA_HIGH:
            next_s.rdata[15:0] = s.abort_capture_data_high;
          periph_bridge_pkg::OFS_ABORT_CONTROLS:
            next_s.rdata[15:0] = s.abort_capture_controls;
          periph_bridge_pkg::OFS_PERMISSION_CONTROL:
            next_s.rdata[15:0] = s.initiator_permission_control;
          periph_bridge_pkg::OFS_IRQ_STATUS:
            next_s.rdata[1:0] = s.irq_status;
          periph_bridge_pkg::OFS_IRQ_MASK:
            next_s.rdata[1:0] = s.irq_mask;
          default: ;
        endcase
      end
    end
    if (s.rvalid && rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end

    // Peripheral access; the factor is frozen per access so a register
    // write mid-cycle cannot tear the strobe waveform
    if (start_ok) begin
      next_s.active      = 1'b1;
      next_s.acc_strobe1 = access_req.strobe1;
      next_s.acc_write   = access_req.write;
      next_s.acc_owner   = access_req.owner;
      next_s.acc_addr    = access_req.addr;
      next_s.acc_wdata   = access_req.wdata;
      next_s.factor      = eff_factor(s.bridge_control[
                             periph_bridge_pkg::STROBE1_LSB +:
                             periph_bridge_pkg::FACTOR_W]);
      next_s.phase       = 5'h00;
      next_s.strobe1_n   = 1'b1;
    end else if (s.active) begin
      if (periph_done || timer_abort.periph) begin
        next_s.active    = 1'b0;
        next_s.strobe1_n = 1'b1;
      end else if (s.acc_strobe1) begin
        next_s.phase     = (s.phase == last_phase) ? 5'h00 :
                           5'(s.phase + 5'h01);
        next_s.strobe1_n = (next_s.phase <
                            {1'b0, s.factor});
      end
    end

    // Abort capture for debug
    if (timer_abort.periph) begin
      events[periph_bridge_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
      next_s.abort_capture_address   = s.acc_addr[15:0];
      next_s.abort_capture_data_low  = s.acc_wdata[15:0];
      next_s.abort_capture_data_high = s.acc_wdata[31:16];
      next_s.abort_capture_controls  =
        {11'h000, s.acc_owner, s.acc_strobe1, s.acc_write, 1'b1};
    end
    events[periph_bridge_pkg::IRQ_REFUSED_BIT] = refused;

    // A new event outranks a clear in the same cycle
    next_s.irq_status = (s.irq_status & ~w1c) | events;
    next_s.irq        = |(next_s.irq_status & next_s.irq_mask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s                              <= '0;
      s.bridge_control               <= periph_bridge_pkg::RST_BRIDGE_CONTROL;
      s.bus_allocation_control       <= periph_bridge_pkg::RST_BUS_ALLOCATION;
      s.core_bridge_control          <=
        periph_bridge_pkg::RST_CORE_BRIDGE_CONTROL;
      s.enhanced_bridge_control      <=
        periph_bridge_pkg::RST_ENHANCED_CONTROL;
      s.initiator_permission_control <=
        periph_bridge_pkg::RST_PERMISSION_CONTROL;
      s.awready                      <= 1'b1;
      s.wready                       <= 1'b1;
      s.arready                      <= 1'b1;
      s.factor                       <= 4'h1;
      s.strobe1_n                    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign awready         = s.awready;
  assign wready          = s.wready;
  assign bvalid          = s.bvalid;
  assign bresp           = s.bresp;
  assign arready         = s.arready;
  assign rvalid          = s.rvalid;
  assign rdata           = s.rdata;
  assign rresp           = s.rresp;
  assign strobe1_n       = s.strobe1_n;
  assign access_busy     = s.active;
  assign periph_abort    = timer_abort.periph;
  assign initiator_abort = timer_abort.initiator;
  assign irq             = s.irq;

endmodule

// ===== periph_model.sv
// Peripheral model that completes bridge accesses after a set delay
`timescale 1ns/1ps
module periph_model (
  // Clock and access state
  input  wire logic       aclk,
  input  wire logic       access_busy,
  input  wire logic [8:0] lat,
  // Completion pulse
  output      logic       periph_done
);
  logic [8:0] cnt;

  // A zero delay stalls for good, so only the time-out can end the access
  always_ff @(posedge aclk)
    cnt <= access_busy ? cnt + 9'h001 : 9'h000;
  assign periph_done = access_busy && lat != 9'h000 && cnt == lat;
endmodule

// ===== periph_bridge_sva.sv
// Concurrent checks on the bridge register bank ports
`timescale 1ns/1ps
module periph_bridge_sva (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus answers
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  // Access side
  input wire logic        periph_done,
  input wire logic        strobe1_n,
  input wire logic        access_busy,
  input wire logic        periph_abort,
  input wire logic [2:0]  initiator_abort
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_abort_onehot:
    assert property (periph_abort |-> $onehot(initiator_abort))
    else $error("abort without a single owner");
  a_abort_pair:
    assert property (|initiator_abort |-> periph_abort)
    else $error("owner abort without peripheral abort");
  a_abort_pulse:
    assert property (periph_abort |-> access_busy ##1 !periph_abort)
    else $error("abort outside an access or too long");
  a_done_quiet:
    assert property (periph_done && access_busy |=> !periph_abort)
    else $error("abort after completion");
  a_end_prompt:
    assert property ((periph_abort || periph_done && access_busy)
                     |=> !access_busy)
    else $error("access stays open");
  // Two idle cycles leave room for the last strobe edge to settle
  a_strobe_idle:
    assert property (!access_busy ##1 !access_busy |-> strobe1_n)
    else $error("strobe active while idle");
  a_rdata_narrow:
    assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("read data wider than a register");
  a_resp_after_take:
    assert property ($rose(bvalid) |-> !awready && !wready)
    else $error("write response before both halves taken");
endmodule

// ===== tb.sv
// Self-checking bench for the bridge register bank and time-out
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] PUB = 32'hFFFED300;
  localparam logic [31:0] PRV = 32'hFFFECA00;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [2:0]  awprot = '0, initiator_abort;
  logic [8:0]  lat = '0;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, strobe1_n;
  logic        access_busy, periph_abort, periph_done, irq;
  periph_bridge_pkg::access_req_t req = '0;
  int          err_total = 0, n_checks = 0, cyc = 0;
  int          fs[4] = '{0, 1, 3, 15};

  periph_bridge_regs_timeout i_dut (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .access_req(req), .periph_done, .strobe1_n,
    .access_busy, .periph_abort, .initiator_abort, .irq);
  periph_model i_per (.aclk, .access_busy, .lat, .periph_done);

  initial forever #2.5 aclk = ~aclk;
  // Whole run is well under a thousand cycles; the ceiling leaves wide margin
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [2:0] p);
    logic aw, w;
    @(posedge aclk);
    {awvalid, wvalid} <= 2'h3;
    {awaddr, wdata, awprot} <= {a, d, p};
    {aw, w} = '0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      aw = aw | awready;
      w = w | wready;
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    check(bresp, 2'h0);
  endtask

  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    check(rdata, ed);
    check(rresp, er);
  endtask

  // Strobe runs are timed on whole periods, so the first phase is skipped
  task automatic access(input periph_bridge_pkg::owner_t o, input int nn,
                        input int l, input int t);
    int k, run, lo, hi, ab;
    logic prev;
    logic [2:0] ia;
    @(posedge aclk);
    {req.start, req.owner, req.strobe1} <= {1'b1, o, nn != 0};
    lat <= 9'(l);
    @(posedge aclk);
    req.start <= 1'b0;
    {run, lo, hi, ab, ia, prev} = '0;
    prev = 1'b1;
    for (k = 1; k < 400; k++) begin
      @(posedge aclk);
      if (k > 1 && !access_busy) break;
      if (periph_abort) {ab, ia} = {k, initiator_abort};
      if (strobe1_n !== prev) begin
        if (!prev && lo == 0) lo = run;
        else if (prev && lo != 0 && hi == 0) hi = run;
        run = 0;
        prev = strobe1_n;
      end
      run++;
    end
    check(ab, t ? t + 2 : 0);
    check(ia, t ? 3'h1 << o : 3'h0);
    check(lo, nn);
    check(hi, nn);
  endtask

  task automatic reset_values;
    access(periph_bridge_pkg::OWNER_CORE, 0, 0, 255);
    rd(PUB, 32'hFF11, 2'h0);
    rd(PRV + 32'h0C, 32'h0001, 2'h0);
  endtask

  task automatic privilege;
    wr(PUB, 32'h1234, 3'h0);
    rd(PRV, 32'hFF11, 2'h0);
    wr(PRV, 32'hABCD0231, 3'h1);
    rd(PUB, 32'h0231, 2'h0);
    rd(PUB + 32'h2C, 32'h0, 2'h3);
  endtask

  // Last abort is a plain DMA read, so the capture shows owner 1 only
  task automatic owner_aborts;
    for (int o = 0; o < 3; o++)
      access(periph_bridge_pkg::owner_t'(o), 0, 0, 2);
    access(periph_bridge_pkg::OWNER_DMA, 0, 2, 0);
    access(periph_bridge_pkg::OWNER_DMA, 0, 0, 2);
    rd(PUB + 32'h1C, 32'h0009, 2'h0);
  endtask

  task automatic strobe_stretch;
    foreach (fs[i]) begin
      wr(PUB, 32'hFF01 | 32'(fs[i]) << 4, 3'h1);
      access(periph_bridge_pkg::OWNER_CORE, fs[i] ? fs[i] : 1,
             4 * (fs[i] ? fs[i] : 1) + 4, 0);
    end
  endtask

  task automatic timeout_off;
    wr(PUB + 32'h0C, 32'h0, 3'h1);
    wr(PUB, 32'h0211, 3'h1);
    access(periph_bridge_pkg::OWNER_SOCKET, 0, 10, 0);
  endtask

  task automatic irq_flow;
    rd(PUB + 32'h24, 32'h0003, 2'h0);
    check(irq, 1'h0);
    wr(PUB + 32'h28, 32'h0001, 3'h1);
    repeat (2) @(posedge aclk);
    check(irq, 1'h1);
    wr(PUB + 32'h24, 32'h0001, 3'h1);
    repeat (2) @(posedge aclk);
    check(irq, 1'h0);
    rd(PUB + 32'h24, 32'h0002, 2'h0);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    privilege();
    owner_aborts();
    strobe_stretch();
    timeout_off();
    irq_flow();
    wrap_up();
  end
endmodule

bind periph_bridge_regs_timeout periph_bridge_sva i_sva (.aclk, .aresetn,
  .awready, .wready, .bvalid, .rvalid, .rdata, .periph_done, .strobe1_n,
  .access_busy, .periph_abort, .initiator_abort);
